// [common/wdr_pkg.sv]
package wdr_pkg;

  // register map (byte addresses, one word each)
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_CLEAR      = 4'h8;
  localparam logic [3:0] ADDR_CONFIG     = 4'hC;

  // control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_PS_LSB   = 1;
  localparam int PS_WIDTH      = 5;
  localparam logic [4:0] PS_RESET     = 5'h0B;
  localparam logic [4:0] PS_MAX_CODE  = 5'h12;
  localparam int BASE_SHIFT    = 5;
  localparam int CNT_WIDTH     = 24;

  // status register fields
  localparam int STAT_TO_BIT    = 0;
  localparam int STAT_PD_BIT    = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_ACT_BIT   = 3;
  localparam int STAT_CNT_LSB   = 8;

  // clear register key
  localparam logic [31:0] CLEAR_KEY = 32'h0000_00A5;

  // mode encodings
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SW     = 2'h1;
  localparam logic [1:0] MODE_NOSLP  = 2'h2;
  localparam logic [1:0] MODE_ON     = 2'h3;

  // oscillator timing
  localparam int CLK_HZ      = 250_000_000;
  localparam int LFOSC_HZ    = 31_000;
  localparam int LF_DIV      = CLK_HZ / LFOSC_HZ;

  typedef struct packed {
    logic [PS_WIDTH-1:0] period_sel;
    logic                sw_enable;
  } wdr_ctrl_type;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } wdr_stat_type;

endpackage

// [verilog/wdr_lf_osc.sv]
`timescale 1ns/1ps
`default_nettype none
// low frequency oscillator stand-in: one-cycle enable per lf period
module wdr_lf_osc #(
  parameter int DIV = wdr_pkg::LF_DIV
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] div_cnt;

  // free running: never cleared by watchdog events
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      div_cnt  <= '0;
      tick_out <= 1'b0;
    end else if (div_cnt == W'(DIV - 1)) begin
      div_cnt  <= '0;
      tick_out <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + W'(1);
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verilog/wdr_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog #(
  parameter int LF_DIV = wdr_pkg::LF_DIV
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // device side
  input  wire logic [1:0]  watchdog_mode_cfg_in,
  input  wire logic        clear_watchdog_instr_in,
  input  wire logic        sleep_enter_in,
  input  wire logic        sleep_exit_in,
  input  wire logic        osc_fail_in,
  input  wire logic        intosc_divider_sel_chg_in,
  output logic             system_reset_out,
  output logic             wake_out,
  output logic             in_sleep_out,
  output logic             timeout_status_flag_out,
  output logic             powerdown_status_flag_out
);

  wdr_pkg::wdr_ctrl_type          watchdog_control;
  wdr_pkg::wdr_stat_type          stat;
  logic                           sleeping;
  logic                           lf_tick;
  logic [wdr_pkg::CNT_WIDTH-1:0]  count;
  logic                           active;
  logic                           clear_now;
  logic                           expired;
  logic                           acc_done;
  logic                           wr_hit;
  logic                           rd_hit;
  logic [31:0]                    next_rdata;

  // ratio for a period code; reserved codes fall back to 1:32
  function automatic logic [wdr_pkg::CNT_WIDTH-1:0] ratio_of(input logic [4:0] code);
    logic [4:0] eff;
    eff = (code > wdr_pkg::PS_MAX_CODE) ? 5'h00 : code;
    ratio_of = wdr_pkg::CNT_WIDTH'(1) << (eff + 5'(wdr_pkg::BASE_SHIFT));
  endfunction

  // byte lane merge for writes
  function automatic logic [7:0] lane0(input logic [7:0] old_v, input logic [31:0] wd,
                                       input logic [3:0] be);
    lane0 = be[0] ? wd[7:0] : old_v;
  endfunction

  wdr_lf_osc #(
    .DIV (LF_DIV)
  ) u_lf_osc (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .tick_out   (lf_tick)
  );

  // activity by mode
  always_comb begin
    unique case (watchdog_mode_cfg_in)
      wdr_pkg::MODE_ON:    active = 1'b1;
      wdr_pkg::MODE_NOSLP: active = !sleeping;
      wdr_pkg::MODE_SW:    active = watchdog_control.sw_enable;
      wdr_pkg::MODE_OFF:   active = 1'b0;
    endcase
  end

  // divider select change is deliberately absent from the clear terms
  assign clear_now = clear_watchdog_instr_in
                   | (sleep_enter_in && !sleeping)
                   | (sleep_exit_in && sleeping)
                   | osc_fail_in
                   | !active;

  assign expired = active && (count >= ratio_of(watchdog_control.period_sel) - wdr_pkg::CNT_WIDTH'(1))
                   && lf_tick;

  // counter
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (clear_now || expired) begin
      count <= '0;
    end else if (lf_tick) begin
      count <= count + wdr_pkg::CNT_WIDTH'(1);
    end
  end

  // sleep state and wake
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sleeping <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      wake_out <= 1'b0;
      if (expired && !clear_now && sleeping) begin
        sleeping <= 1'b0;
        wake_out <= 1'b1;
      end else if (sleep_exit_in && sleeping) begin
        sleeping <= 1'b0;
      end else if (sleep_enter_in && !sleeping) begin
        sleeping <= 1'b1;
      end
    end
  end

  // reset request: one cycle pulse, only when awake
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      system_reset_out <= 1'b0;
    end else begin
      system_reset_out <= expired && !clear_now && !sleeping;
    end
  end

  // status flags: timeout flag low after watchdog event, powerdown low after sleep entry
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      stat.timeout_flag   <= 1'b1;
      stat.powerdown_flag <= 1'b1;
    end else if (expired && !clear_now) begin
      stat.timeout_flag   <= 1'b0;
    end else if (sleep_enter_in && !sleeping) begin
      stat.timeout_flag   <= 1'b1;
      stat.powerdown_flag <= 1'b0;
    end else if (clear_watchdog_instr_in) begin
      stat.timeout_flag   <= 1'b1;
      stat.powerdown_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      in_sleep_out              <= 1'b0;
      timeout_status_flag_out   <= 1'b1;
      powerdown_status_flag_out <= 1'b1;
    end else begin
      in_sleep_out              <= sleeping;
      timeout_status_flag_out   <= stat.timeout_flag;
      powerdown_status_flag_out <= stat.powerdown_flag;
    end
  end

  // avalon slave: one wait cycle, answer on the second edge
  assign wr_hit = avs_write_in && !avs_read_in;
  assign rd_hit = avs_read_in && !avs_write_in;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      acc_done            <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else if ((wr_hit || rd_hit) && !acc_done) begin
      acc_done            <= 1'b1;
      avs_waitrequest_out <= 1'b0;
    end else begin
      acc_done            <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end
  end

  // control register; only byte lane 0 holds bits
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      watchdog_control.period_sel <= wdr_pkg::PS_RESET;
      watchdog_control.sw_enable  <= 1'b0;
    end else if (wr_hit && acc_done && avs_address_in == wdr_pkg::ADDR_CONTROL) begin
      {watchdog_control.period_sel, watchdog_control.sw_enable} <=
        6'(lane0({2'h0, watchdog_control.period_sel, watchdog_control.sw_enable},
                 avs_writedata_in, avs_byteenable_in));
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (avs_address_in)
      wdr_pkg::ADDR_CONTROL: begin
        next_rdata[wdr_pkg::CTRL_EN_BIT] = watchdog_control.sw_enable;
        next_rdata[wdr_pkg::CTRL_PS_LSB +: wdr_pkg::PS_WIDTH] = watchdog_control.period_sel;
      end
      wdr_pkg::ADDR_STATUS: begin
        next_rdata[wdr_pkg::STAT_TO_BIT]    = stat.timeout_flag;
        next_rdata[wdr_pkg::STAT_PD_BIT]    = stat.powerdown_flag;
        next_rdata[wdr_pkg::STAT_SLEEP_BIT] = sleeping;
        next_rdata[wdr_pkg::STAT_ACT_BIT]   = active;
        next_rdata[wdr_pkg::STAT_CNT_LSB +: wdr_pkg::CNT_WIDTH] = count;
      end
      wdr_pkg::ADDR_CONFIG: next_rdata[1:0] = watchdog_mode_cfg_in;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_hit && !acc_done) begin
      avs_readdata_out <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// [tb/wdr_watchdog_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_chk (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [1:0] watchdog_mode_cfg_in,
  input wire logic       clear_watchdog_instr_in,
  input wire logic       sleep_enter_in,
  input wire logic       sleep_exit_in,
  input wire logic       osc_fail_in,
  input wire logic       system_reset_out,
  input wire logic       wake_out,
  input wire logic       in_sleep_out,
  input wire logic       timeout_status_flag_out,
  input wire logic       powerdown_status_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_asleep; in_sleep_out && timeout_status_flag_out && !powerdown_status_flag_out; endsequence
  sequence s_woken; !in_sleep_out && !timeout_status_flag_out; endsequence
  property p_ack; !avs_waitrequest_out |-> $past(avs_read_in ^ avs_write_in) ##1 avs_waitrequest_out; endproperty
  property p_rst_pulse; system_reset_out |=> !system_reset_out; endproperty
  property p_off; (watchdog_mode_cfg_in == wdr_pkg::MODE_OFF) [*2] |-> !system_reset_out && !wake_out; endproperty
  property p_clr; clear_watchdog_instr_in |=> !system_reset_out && !wake_out; endproperty
  property p_fail; osc_fail_in |=> !system_reset_out && !wake_out; endproperty
  // status outputs are a second flop behind the sleep state, so they settle two edges later
  property p_enter; sleep_enter_in |=> ##1 s_asleep; endproperty
  property p_exit; sleep_exit_in |=> ##1 !in_sleep_out; endproperty
  property p_wake; wake_out |-> !system_reset_out ##1 s_woken; endproperty
  property p_noslp; watchdog_mode_cfg_in == wdr_pkg::MODE_NOSLP |-> !wake_out; endproperty
  a_ack: assert property (p_ack) else $error("waitrequest low without a single request");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse longer than one cycle");
  a_off: assert property (p_off) else $error("event while mode is off");
  a_clr: assert property (p_clr) else $error("event right after clear");
  a_fail: assert property (p_fail) else $error("event right after oscillator failure");
  a_enter: assert property (p_enter) else $error("sleep entry state wrong");
  a_exit: assert property (p_exit) else $error("sleep not left");
  a_wake: assert property (p_wake) else $error("wake state wrong");
  a_noslp: assert property (p_noslp) else $error("wake in off-in-sleep mode");
endmodule
bind wdr_watchdog wdr_watchdog_chk u_wdr_watchdog_chk (.*);
`default_nettype wire

// [tb/wdr_watchdog_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_tb_top;
  logic        clk_sys_in = 0, rst_n_in = 0, rd = 0, wr = 0, srst, wake, slp, tof, pdf, wt;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, q, rdata;
  logic [1:0]  mode = wdr_pkg::MODE_OFF;
  logic [4:0]  pv = 5'h00;
  int          err_total = 0, compares = 0, n;
  wdr_watchdog #(.LF_DIV(4)) u_wdr_watchdog (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .watchdog_mode_cfg_in(mode), .clear_watchdog_instr_in(pv[0]), .sleep_enter_in(pv[1]),
    .sleep_exit_in(pv[2]), .osc_fail_in(pv[3]), .intosc_divider_sel_chg_in(pv[4]),
    .system_reset_out(srst), .wake_out(wake), .in_sleep_out(slp),
    .timeout_status_flag_out(tof), .powerdown_status_flag_out(pdf));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  task conclude;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    do @(posedge clk_sys_in); while (wt !== 1'b0);
    q = rdata; rd <= 1'b0; wr <= 1'b0;
  endtask
  task pulse(input int b);
    @(posedge clk_sys_in); pv[b] <= 1'b1;
    @(posedge clk_sys_in); pv[b] <= 1'b0;
  endtask
  // cycles until a reset or wake pulse, lim if none
  task meas(input int lim);
    n = 0;
    do begin @(negedge clk_sys_in); n++; end while (srst !== 1'b1 && wake !== 1'b1 && n < lim);
  endtask
  task t_per(input logic [4:0] c, input int r, input logic wk);
    bus(1'b1, wdr_pkg::ADDR_CONTROL, {26'h0, c, 1'b1}); pulse(0);
    meas(r * 4 + 20);
    cmp({n >= r * 4 - 6 && n <= r * 4 + 6, wake, srst}, {1'b1, wk, !wk});
  endtask
  task t_regs;
    bus(1'b0, wdr_pkg::ADDR_CONTROL, 32'h0); cmp(q, 32'h0000_0016);
    bus(1'b0, wdr_pkg::ADDR_STATUS, 32'h0); cmp(q, 32'h0000_0003);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF); bus(1'b0, 4'h2, 32'h0); cmp(q, 32'h0);
    bus(1'b0, wdr_pkg::ADDR_CLEAR, 32'h0); cmp(q, 32'h0);
    bus(1'b0, wdr_pkg::ADDR_CONTROL, 32'h0); cmp(q, 32'h0000_0016);
  endtask
  task t_modes;
    bus(1'b1, wdr_pkg::ADDR_CONTROL, 32'h1); meas(300); cmp(n, 300);
    mode <= wdr_pkg::MODE_SW; bus(1'b1, wdr_pkg::ADDR_CONTROL, 32'h0); meas(300); cmp(n, 300);
    t_per(5'h00, 32, 1'b0);
    mode <= wdr_pkg::MODE_NOSLP; t_per(5'h00, 32, 1'b0);
    mode <= wdr_pkg::MODE_ON; t_per(5'h01, 64, 1'b0);
    t_per(5'h13, 32, 1'b0);
    bus(1'b0, wdr_pkg::ADDR_CONTROL, 32'h0); cmp(q, 32'h0000_0027);
  endtask
  task t_sleep;
    mode <= wdr_pkg::MODE_NOSLP; t_per(5'h00, 32, 1'b0); pulse(1);
    bus(1'b0, wdr_pkg::ADDR_STATUS, 32'h0); cmp(q, 32'h0000_0005);
    meas(300); cmp(n, 300); pulse(2);
    mode <= wdr_pkg::MODE_ON; pulse(1); meas(100); pulse(2); meas(100); cmp(n, 100);
    pulse(1); meas(200); cmp({n > 120 && n < 136, wake}, 2'h3);
    bus(1'b0, wdr_pkg::ADDR_STATUS, 32'h0); cmp(q[2:0], 3'h0);
    mode <= wdr_pkg::MODE_SW; pulse(1); meas(200); cmp(wake, 1'b1);
  endtask
  task t_clears;
    mode <= wdr_pkg::MODE_ON; pulse(0); meas(100); cmp(n, 100);
    pulse(3); meas(100); cmp(n, 100);
    pulse(4); meas(200); cmp(n > 16 && n < 36 && srst, 1'b1);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    conclude;
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_modes;
    t_sleep;
    t_clears;
    conclude;
  end
endmodule
`default_nettype wire
